// file: rtl/raoc_pkg.sv
// shared constants and types of the reset and option control block
package raoc_pkg;

	// clock and timing
	localparam int CLK_KHZ         = 100000;
	localparam int RTC_PERIOD_MS   = 500;
	localparam int RTC_CYCLES      = RTC_PERIOD_MS * CLK_KHZ;
	localparam int RC_WARM_US      = 1;
	localparam int RC_WARM_CYCLES  = RC_WARM_US * CLK_KHZ / 1000;
	localparam int XTAL_WARM_US    = 64;
	localparam int XTAL_WARM_CYCLES = XTAL_WARM_US * CLK_KHZ / 1000;
	localparam int WARM_W          = 24;
	localparam int RTC_W           = 27;

	// register map: word indices, byte address is four times
	localparam logic [9:0]  PROG_FLAGS_IDX = 10'h086;
	localparam logic [9:0]  OPTION_IDX  = 10'h088;
	localparam logic [9:0]  STATUS_IDX  = 10'h089;
	localparam int          ADR_W       = 12;

	// program_flags fields
	localparam int CAUSE_HI   = 7;
	localparam int CAUSE_LO   = 6;
	localparam int FLAG_HIGH  = 5;
	localparam int FLAG_MID   = 4;
	localparam logic [2:0] ALU_RESET  = 3'h0;
	localparam logic [7:0] FLAGS_RW_MASK = 8'h07;

	// reset cause encodings
	localparam logic [1:0] CAUSE_WDT = 2'h0;
	localparam logic [1:0] CAUSE_POR = 2'h2;
	localparam logic [1:0] CAUSE_EXT = 2'h3;

	// option register fields
	localparam int OPT_FCPU_LO = 0;
	localparam int OPT_CLK_LO  = 2;
	localparam int OPT_WDT_LO  = 5;
	localparam int OPT_PIN     = 7;
	localparam int OPT_LVD_LO  = 8;
	localparam int OPT_SEC     = 10;
	localparam int OPT_W       = 11;
	localparam logic [10:0] OPT_RESET = 11'h020;

	typedef enum logic [1:0] {
		RAOC_DIV1 = 2'h0,
		RAOC_DIV2 = 2'h1,
		RAOC_DIV4 = 2'h2,
		RAOC_DIV8 = 2'h3
	} raoc_fcpu_t;

	typedef enum logic [2:0] {
		RAOC_CLK_IRC     = 3'h0,
		RAOC_CLK_IRC_RTC = 3'h1,
		RAOC_CLK_EXT_RC  = 3'h2,
		RAOC_CLK_X32K    = 3'h3,
		RAOC_CLK_X8M     = 3'h4,
		RAOC_CLK_X4M     = 3'h5
	} raoc_clk_t;

	typedef enum logic [1:0] {
		RAOC_WDT_ALWAYS  = 2'h0,
		RAOC_WDT_ENABLE  = 2'h1,
		RAOC_WDT_DISABLE = 2'h2
	} raoc_wdt_t;

	typedef enum logic [1:0] {
		RAOC_LVD_LOW  = 2'h0,
		RAOC_LVD_MID  = 2'h1,
		RAOC_LVD_HIGH = 2'h2
	} raoc_lvd_t;

	// gray coded along power-up, pin wait, init, warm-up, run
	typedef enum logic [2:0] {
		RAOC_ST_POWER = 3'b000,
		RAOC_ST_PIN   = 3'b001,
		RAOC_ST_INIT  = 3'b011,
		RAOC_ST_WARM  = 3'b010,
		RAOC_ST_RUN   = 3'b110
	} raoc_state_t;

endpackage

// file: rtl/raoc_sync.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module raoc_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule // raoc_sync

`default_nettype wire

// file: rtl/raoc_top.sv
// reset sequencer, code options and program flags behind classic wishbone
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE1] instruction cycle enable every 1, 2, 4 or 8 clocks by option
// [RULE2] internal rc option hands both oscillator pins to port 0 bits 3, 4
// [RULE3] internal rc with timebase adds half-second tick, pins freed as well
// [RULE4] external rc keeps oscillator input, output pin becomes port bit 4
// [RULE5] always-on watchdog counts in every mode, low power included
// [RULE6] enable option halts watchdog in low power; disable never resets
// [RULE7] reset-pin function resets system on falling pin edge
// [RULE8] port function ignores pin for reset, reads it as input bit 0.2
// [RULE9] low and middle options reset below 1.8 V; middle adds mid flag
// [RULE10] high option resets below 2.4 V and enables high flag
// [RULE11] security option blocks full program memory read-out
// [RULE12] power-on, watchdog, brown-out and pin resets; pin only if enabled
// [RULE13] any reset reinitialises registers, halts cpu, restarts at zero
// [RULE14] cause bits 7:6 read 00 watchdog, 10 power or brown-out, 11 pin
// [RULE15] power-up waits supply, then pin high, init, warm-up, run
// [RULE16] watchdog overflow goes through init and warm-up to restart
// [RULE17] warm-up is short for rc sources, long for crystals
// [RULE18] firmware clears watchdog from one place in main code only
// [RULE19] enabled supply flags follow detector level, disabled stay zero
// [RULE20] any brown-out or reset sequence clears both supply flags
// [RULE21] pin and detector inputs pass two flip-flops before use
module raoc_top #(
	parameter int RTC_CYC     = raoc_pkg::RTC_CYCLES,
	parameter int XTAL_WARM   = raoc_pkg::XTAL_WARM_CYCLES,
	parameter int RC_WARM     = raoc_pkg::RC_WARM_CYCLES
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [raoc_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     supply_ok_i,
	input  wire logic                     below_18_i,
	input  wire logic                     below_24_i,
	input  wire logic                     below_28_i,
	input  wire logic                     reset_pin_i,
	input  wire logic                     wdt_overflow_i,
	input  wire logic                     power_down_i,
	input  wire logic                     green_mode_i,
	output logic                          sys_reset_o,
	output logic                          cpu_run_o,
	output logic                          cpu_cycle_en_o,
	output logic [12:0]                   start_addr_o,
	output logic                          osc_input_port_o,
	output logic                          osc_output_port_o,
	output logic                          timebase_tick_o,
	output logic                          wdt_count_en_o,
	output logic                          input_only_pin_o,
	output logic                          readout_block_o
);
	import raoc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [4:0] async_w;
	logic [4:0] sync_w;
	logic       ok_s, b18_s, b24_s, b28_s, pin_s;

	assign async_w = {supply_ok_i, below_18_i, below_24_i, below_28_i,
		reset_pin_i};
	// [RULE21] two-stage capture
	raoc_sync #(.W(5), .RST_VAL(5'h01)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (async_w),
		.sync_o  (sync_w)
	);
	assign {ok_s, b18_s, b24_s, b28_s, pin_s} = sync_w;

	////////////////////////////////////////////////////////////////////////
	// option decode
	logic [OPT_W-1:0] opt_q, opt_d;
	raoc_fcpu_t       fcpu;
	raoc_clk_t        hclk;
	raoc_wdt_t        wdt_mode;
	raoc_lvd_t        lvd_mode;
	logic             pin_is_port;

	assign fcpu        = raoc_fcpu_t'(opt_q[OPT_FCPU_LO +: 2]);
	assign hclk        = raoc_clk_t'(opt_q[OPT_CLK_LO +: 3]);
	assign wdt_mode    = raoc_wdt_t'(opt_q[OPT_WDT_LO +: 2]);
	assign lvd_mode    = raoc_lvd_t'(opt_q[OPT_LVD_LO +: 2]);
	assign pin_is_port = opt_q[OPT_PIN];

	function automatic logic is_rc(input raoc_clk_t c);
		return (c == RAOC_CLK_IRC) || (c == RAOC_CLK_IRC_RTC) ||
			(c == RAOC_CLK_EXT_RC);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset sources
	logic pin_q, pin_d;
	logic brown_ev, ext_ev, wdt_ev, por_ev;

	// [RULE9] [RULE10] threshold chosen by brown-out option
	assign brown_ev = (lvd_mode == RAOC_LVD_HIGH) ? b24_s : b18_s;
	assign por_ev   = !ok_s || brown_ev;
	// [RULE7] [RULE8] [RULE12] falling pin edge only with reset function
	assign ext_ev   = !pin_is_port && pin_q && !pin_s;
	// [RULE6] disabled watchdog never resets
	assign wdt_ev   = wdt_overflow_i && (wdt_mode != RAOC_WDT_DISABLE);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	raoc_state_t       st_q, st_d;
	logic [WARM_W-1:0] warm_q, warm_d;
	logic [1:0]        cause_q, cause_d;
	logic [WARM_W-1:0] warm_len;

	// [RULE17] warm-up length by oscillator kind
	assign warm_len = is_rc(hclk) ? WARM_W'(RC_WARM) : WARM_W'(XTAL_WARM);

	always_comb begin
		st_d    = st_q;
		warm_d  = warm_q;
		cause_d = cause_q;
		case (st_q)
			// [RULE15] wait for stable supply
			RAOC_ST_POWER: begin
				if (!por_ev) begin
					st_d = pin_is_port ? RAOC_ST_INIT : RAOC_ST_PIN;
				end
			end
			// [RULE15] hold while the pin is not high
			RAOC_ST_PIN: begin
				if (pin_is_port || pin_s) begin
					st_d = RAOC_ST_INIT;
				end
			end
			// [RULE13] registers return to initial values here
			RAOC_ST_INIT: begin
				st_d   = RAOC_ST_WARM;
				warm_d = '0;
			end
			RAOC_ST_WARM: begin
				warm_d = warm_q + WARM_W'(1);
				if (warm_q >= warm_len - WARM_W'(1)) begin
					st_d = RAOC_ST_RUN;
				end
			end
			RAOC_ST_RUN: begin
				// [RULE16] watchdog restart skips power and pin checks
				if (wdt_ev) begin
					st_d    = RAOC_ST_INIT;
					cause_d = CAUSE_WDT;
				end
			end
			default: st_d = RAOC_ST_POWER;
		endcase
		// [RULE12] [RULE14] pin reset outranks watchdog
		if (ext_ev && st_q != RAOC_ST_POWER) begin
			st_d    = RAOC_ST_PIN;
			cause_d = CAUSE_EXT;
		end
		// [RULE14] power-on and brown-out win over all
		if (por_ev) begin
			st_d    = RAOC_ST_POWER;
			cause_d = CAUSE_POR;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q    <= RAOC_ST_POWER;
			warm_q  <= '0;
			cause_q <= CAUSE_POR;
			pin_q   <= 1'b1;
		end else begin
			st_q    <= st_d;
			warm_q  <= warm_d;
			cause_q <= cause_d;
			pin_q   <= pin_d;
		end
	end
	assign pin_d = pin_s;

	////////////////////////////////////////////////////////////////////////
	// instruction cycle divider and timebase
	logic [2:0]       div_q, div_d;
	logic [RTC_W-1:0] rtc_q, rtc_d;
	logic             cyc_q, cyc_d, tick_q, tick_d;
	logic [2:0]       div_last;
	logic             running;

	assign running  = (st_q == RAOC_ST_RUN);
	// [RULE1] divide ratio 1, 2, 4 or 8
	assign div_last = 3'((4'h1 << fcpu) - 4'h1);

	always_comb begin
		div_d  = '0;
		cyc_d  = 1'b0;
		rtc_d  = '0;
		tick_d = 1'b0;
		if (running) begin
			div_d = (div_q >= div_last) ? 3'h0 : div_q + 3'h1;
			cyc_d = (div_q >= div_last);
		end
		// [RULE3] half-second tick only with timebase option
		if (hclk == RAOC_CLK_IRC_RTC) begin
			if (rtc_q >= RTC_W'(RTC_CYC - 1)) begin
				tick_d = 1'b1;
			end else begin
				rtc_d = rtc_q + RTC_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q  <= '0;
			cyc_q  <= 1'b0;
			rtc_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			cyc_q  <= cyc_d;
			rtc_q  <= rtc_d;
			tick_q <= tick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave and registers
	logic       ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [7:0] alu_q, alu_d;
	logic [1:0] flg_q, flg_d;
	logic [7:0] flags_word;
	logic [7:0] status;
	logic       wr, rd;
	logic [9:0] idx;

	assign idx    = wb_adr_i[ADR_W-1:2];
	// write lands on the edge at which the master sees ack high
	assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
	assign rd     = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
	assign flags_word = {cause_q, flg_q, 1'b0, alu_q[2:0]};
	assign status = {pin_s && pin_is_port, readout_block_o, wdt_count_en_o,
		osc_output_port_o, osc_input_port_o, st_q};

	always_comb begin
		ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
		dat_d   = 32'h0000_0000;
		opt_d   = opt_q;
		alu_d   = alu_q;
		flg_d   = 2'h0;
		// [RULE19] flags follow detector only when their level is enabled
		if (running) begin
			flg_d[1] = (lvd_mode == RAOC_LVD_HIGH) && b28_s;
			flg_d[0] = (lvd_mode != RAOC_LVD_LOW) && b24_s;
		end
		if (rd) begin
			case (idx)
				PROG_FLAGS_IDX: dat_d = {24'h0, flags_word};
				OPTION_IDX: dat_d = {21'h0, opt_q};
				STATUS_IDX: dat_d = {24'h0, status};
				default:    dat_d = 32'h0000_0000;
			endcase
		end
		if (wr && idx == PROG_FLAGS_IDX && wb_sel_i[0]) begin
			alu_d = wb_dat_i[7:0] & FLAGS_RW_MASK;
		end
		if (wr && idx == OPTION_IDX) begin
			if (wb_sel_i[0]) opt_d[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1]) opt_d[OPT_W-1:8] = wb_dat_i[OPT_W-1:8];
		end
		// [RULE13] system registers back to initial values in reset
		if (!running) begin
			alu_d = {5'h00, ALU_RESET};
		end
	end

	// cause bits load from hardware only, so no set and clear race
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
			opt_q <= OPT_RESET;
			alu_q <= '0;
			flg_q <= '0;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
			opt_q <= opt_d;
			alu_q <= alu_d;
			// [RULE20] flags held clear through every reset sequence
			flg_q <= flg_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////////////////
	// option driven outputs, all but the fixed start address from flip-flops
	logic [7:0] outv_q, outv_d;

	always_comb begin
		outv_d = '0;
		outv_d[0] = !running;
		outv_d[1] = (st_d == RAOC_ST_RUN) && running;
		// [RULE2] [RULE3] internal rc frees both pins
		outv_d[2] = (hclk == RAOC_CLK_IRC) || (hclk == RAOC_CLK_IRC_RTC);
		// [RULE4] external rc frees output pin only
		outv_d[3] = outv_d[2] || (hclk == RAOC_CLK_EXT_RC);
		// [RULE5] [RULE6] watchdog clock gating by mode
		outv_d[4] = (wdt_mode == RAOC_WDT_ALWAYS) ||
			((wdt_mode == RAOC_WDT_ENABLE) && !power_down_i && !green_mode_i);
		// [RULE8] pin read as plain input in port mode
		outv_d[5] = pin_is_port && pin_s;
		// [RULE11] read-out block
		outv_d[6] = opt_q[OPT_SEC];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			outv_q <= 8'h01;
		end else begin
			outv_q <= outv_d;
		end
	end

	assign sys_reset_o       = outv_q[0];
	assign cpu_run_o         = outv_q[1];
	assign osc_input_port_o  = outv_q[2];
	assign osc_output_port_o = outv_q[3];
	assign wdt_count_en_o    = outv_q[4];
	assign input_only_pin_o  = outv_q[5];
	assign readout_block_o   = outv_q[6];
	assign cpu_cycle_en_o    = cyc_q;
	assign timebase_tick_o   = tick_q;
	// [RULE13] execution restarts at address zero
	assign start_addr_o      = 13'h0000;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_pin_edge_reset: assert property ( // [RULE7]
		(running && !pin_is_port && pin_q && !pin_s && ok_s && !brown_ev)
		|=> st_q == RAOC_ST_PIN && cause_q == CAUSE_EXT)
		else $error("pin edge did not reset");
	a_port_no_reset: assert property ( // [RULE8]
		(running && pin_is_port && !por_ev && !wdt_ev)
		|=> st_q == RAOC_ST_RUN)
		else $error("pin reset in port mode");
	a_wdt_disabled: assert property ( // [RULE6]
		(running && wdt_mode == RAOC_WDT_DISABLE && !por_ev && !ext_ev)
		|=> st_q == RAOC_ST_RUN)
		else $error("disabled watchdog reset");
	a_wdt_low_power: assert property ( // [RULE6]
		(wdt_mode == RAOC_WDT_ENABLE && power_down_i && $stable(opt_q))
		|=> !wdt_count_en_o)
		else $error("watchdog ran in power down");
	a_wdt_always: assert property ( // [RULE5]
		(wdt_mode == RAOC_WDT_ALWAYS && $stable(opt_q)) |=> wdt_count_en_o)
		else $error("always-on watchdog stopped");
	a_brown_cause: assert property ( // [RULE14]
		por_ev |=> st_q == RAOC_ST_POWER && cause_q == CAUSE_POR)
		else $error("brown-out cause wrong");
	a_wdt_restart: assert property ( // [RULE16]
		(running && wdt_ev && !por_ev && !ext_ev)
		|=> st_q == RAOC_ST_INIT ##1 st_q == RAOC_ST_WARM)
		else $error("watchdog restart path wrong");
	a_flag_clear: assert property ( // [RULE20]
		!running |=> flg_q == 2'h0)
		else $error("flags not cleared in reset");
	a_flag_low_opt: assert property ( // [RULE19]
		(lvd_mode == RAOC_LVD_LOW) |=> flg_q == 2'h0)
		else $error("disabled flag set");
	a_div8_gap: assert property ( // [RULE1]
		(cyc_q && fcpu == RAOC_DIV8 && running && $stable(opt_q) && !por_ev
		&& !ext_ev && !wdt_ev) |=> (!cyc_q || fcpu != RAOC_DIV8) [*7])
		else $error("divide by eight broken");
	a_rc_warm: assert property ( // [RULE17]
		(st_q == RAOC_ST_INIT && RC_WARM == 1 && is_rc(hclk) && !por_ev
		&& !ext_ev && $stable(opt_q)) |=> ##1 st_q == RAOC_ST_RUN)
		else $error("rc warm-up length wrong");
	a_run_after_warm: assert property ( // [RULE15]
		$rose(cpu_run_o) |-> $past(st_q, 2) == RAOC_ST_WARM)
		else $error("run without warm-up");

	c_pin_reset:  cover property (running ##1 st_q == RAOC_ST_PIN);
	c_wdt_reset:  cover property (running && wdt_ev);
	c_brown:      cover property (running ##1 st_q == RAOC_ST_POWER);
	c_flag_high:  cover property (flg_q[1]);

endmodule // raoc_top

`default_nettype wire

// file: sim/raoc_partner.sv
// supply detector and external reset pin seen from outside the block
`timescale 1ns/1ps
`default_nettype none

module raoc_partner (
	input  var   int   vdd_mv_i,
	input  wire  logic pin_low_i,
	output logic       supply_ok_o,
	output logic       below_18_o,
	output logic       below_24_o,
	output logic       below_28_o,
	output logic       reset_pin_o
);
	// levels are reported at or below, as a real comparator would
	always_comb begin
		supply_ok_o = vdd_mv_i > 1800;
		below_18_o  = vdd_mv_i <= 1800;
		below_24_o  = vdd_mv_i <= 2400;
		below_28_o  = vdd_mv_i <= 2800;
		reset_pin_o = !pin_low_i;
	end
endmodule // raoc_partner

`default_nettype wire

// file: sim/reset_and_option_control_tb_top.sv
// self-checking bench for the reset and option control block
`timescale 1ns/1ps
`default_nettype none

module reset_and_option_control_tb_top;
	import raoc_pkg::*;

	localparam logic [11:0] A_FLG = {PROG_FLAGS_IDX, 2'b00};
	localparam logic [11:0] A_OPT = {OPTION_IDX, 2'b00};
	localparam logic [11:0] A_STA = {STATUS_IDX, 2'b00};

	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        supply_ok_i, below_18_i, below_24_i, below_28_i;
	logic        reset_pin_i, wdt_overflow_i, power_down_i, green_mode_i;
	logic        sys_reset_o, cpu_run_o, cpu_cycle_en_o, timebase_tick_o;
	logic        osc_input_port_o, osc_output_port_o, wdt_count_en_o;
	logic        input_only_pin_o, readout_block_o, pin_low;
	logic [12:0] start_addr_o;
	int          vdd_mv, err_total, n_tests, cyc_cnt, opt_m, cause_m, alu_m;
	int          en, tk;

	raoc_top #(.RTC_CYC(20), .XTAL_WARM(8), .RC_WARM(1)) dut_u (.*);

	raoc_partner part_u (
		.vdd_mv_i    (vdd_mv),
		.pin_low_i   (pin_low),
		.supply_ok_o (supply_ok_i),
		.below_18_o  (below_18_i),
		.below_24_o  (below_24_i),
		.below_28_o  (below_28_i),
		.reset_pin_o (reset_pin_i)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// a hang ends the run as a mismatch
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s exp %0h got %0h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		chk("wb ack", 1, wb_ack_o);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, logic [11:0] a, logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	function automatic logic [31:0] flg_exp();
		int lvd;
		lvd = (opt_m >> 8) & 3;
		return 32'((cause_m << 6) | ((lvd == 2 && vdd_mv <= 2800) << 5)
			| (((lvd == 1 || lvd == 2) && vdd_mv <= 2400) << 4) | alu_m);
	endfunction

	task automatic set_opt(input int v);
		int c;
		wb(1'b1, A_OPT, 32'(v));
		opt_m = v;
		c = (v >> 2) & 7;
		repeat (4) @(posedge clk_i);
		#1;
		rd_chk("options", A_OPT, 32'(v));
		chk("osc in port", c < 2, osc_input_port_o);
		chk("osc out port", c < 3, osc_output_port_o);
		chk("wdt en", ((v >> 5) & 3) != 2, wdt_count_en_o);
		chk("port pin", ((v >> 7) & 1) && !pin_low, input_only_pin_o);
		chk("readout", (v >> 10) & 1, readout_block_o);
	endtask

	task automatic wait_on(input logic run);
		int n;
		n = 0;
		while ((run ? cpu_run_o : sys_reset_o) !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		chk(run ? "run reached" : "reset seen", 1, run ? cpu_run_o : sys_reset_o);
		@(posedge clk_i);
	endtask

	task automatic count(input int n);
		en = 0;
		tk = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			en += cpu_cycle_en_o;
			tk += timebase_tick_o;
		end
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wdt_overflow_i} = '0;
		{power_down_i, green_mode_i, pin_low} = '0;
		wb_adr_i = '0;
		wb_sel_i = '0;
		wb_dat_i = '0;
		vdd_mv = 3300;
		rst_i = 1'b1;
		{err_total, n_tests, cyc_cnt, alu_m} = '0;
		void'($urandom(32'hea6d));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_on(1'b1);
		cause_m = 2;
		opt_m = OPT_RESET;
		chk("start addr", 0, start_addr_o);
		rd_chk("flags", A_FLG, flg_exp());
		rd_chk("options", A_OPT, 32'(OPT_RESET));
		rd_chk("status", A_STA, 32'h3E);
		wb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
		rd_chk("unmapped", 12'hFFC, 32'h0);
		rd = $urandom();
		alu_m = rd & 7;
		wb(1'b1, A_FLG, rd);
		rd_chk("flags", A_FLG, flg_exp());
		$display("test registers done");

		for (int i = 0; i < 6; i++) begin
			set_opt((i << 2) | (i % 4) | ((i & 1) << 10) | 32'h20);
			count(80);
			chk("cycle en", 80 >> (i % 4), en);
			chk("timebase", (i == 1) ? 4 : 0, tk);
		end
		$display("test options done");

		for (int w = 0; w < 3; w++) begin
			set_opt(w << 5);
			for (int m = 0; m < 3; m++) begin
				@(posedge clk_i);
				power_down_i <= (m == 1);
				green_mode_i <= (m == 2);
				repeat (3) @(posedge clk_i);
				#1;
				chk("wdt lp", w == 0 || (w == 1 && m == 0), wdt_count_en_o);
			end
			@(posedge clk_i);
			power_down_i <= 1'b0;
			green_mode_i <= 1'b0;
		end
		@(posedge clk_i);
		wdt_overflow_i <= 1'b1;
		@(posedge clk_i);
		wdt_overflow_i <= 1'b0;
		// overflow comes as a lone pulse, one clearing point
		repeat (10) @(posedge clk_i);
		chk("no wdt reset", 1, cpu_run_o);
		set_opt(32'h20);
		wb(1'b1, A_FLG, 32'h5);
		@(posedge clk_i);
		wdt_overflow_i <= 1'b1;
		@(posedge clk_i);
		wdt_overflow_i <= 1'b0;
		wait_on(1'b0);
		wait_on(1'b1);
		cause_m = 0;
		alu_m = 0;
		rd_chk("flags", A_FLG, flg_exp());
		$display("test watchdog done");

		set_opt(32'hA0);
		@(posedge clk_i);
		pin_low <= 1'b1;
		repeat (6) @(posedge clk_i);
		#1;
		chk("port run", 1, cpu_run_o);
		chk("port pin", 0, input_only_pin_o);
		@(posedge clk_i);
		pin_low <= 1'b0;
		set_opt(32'h20);
		@(posedge clk_i);
		pin_low <= 1'b1;
		wait_on(1'b0);
		repeat (20) @(posedge clk_i);
		chk("pin hold", 1, sys_reset_o);
		pin_low <= 1'b0;
		wait_on(1'b1);
		cause_m = 3;
		rd_chk("flags", A_FLG, flg_exp());
		$display("test pin done");

		set_opt(32'h100);
		vdd_mv <= 2300;
		repeat (6) @(posedge clk_i);
		chk("mid run", 1, cpu_run_o);
		rd_chk("flags", A_FLG, flg_exp());
		set_opt(32'h0);
		rd_chk("flags", A_FLG, flg_exp());
		vdd_mv <= 2600;
		set_opt(32'h200);
		rd_chk("flags", A_FLG, flg_exp());
		vdd_mv <= 2300;
		wait_on(1'b0);
		vdd_mv <= 3300;
		wait_on(1'b1);
		cause_m = 2;
		rd_chk("flags", A_FLG, flg_exp());
		set_opt(32'h100);
		vdd_mv <= 1700;
		wait_on(1'b0);
		vdd_mv <= 3300;
		wait_on(1'b1);
		rd_chk("flags", A_FLG, flg_exp());
		$display("test supply done");
		end_sim();
	end
endmodule // reset_and_option_control_tb_top

`default_nettype wire
